//--- inc/timer_defs.svh
// Register offsets, field positions, mode codes and constants of the composite timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// ==============================================================
// Register offsets
`define ADDR_CR1_B    12'h036
`define ADDR_CR1_A    12'h037
`define ADDR_CR0_B    12'hF92
`define ADDR_CR0_A    12'hF93
`define ADDR_DATA_B   12'hF94
`define ADDR_DATA_A   12'hF95
`define ADDR_PAIR_CTL 12'hF96
`define RESET_BYTE    8'h00
// ==============================================================
// Field positions
`define CR0_IFE  7
`define CR1_RUN  7
`define CR1_HOLD 6
`define CR1_IE   5
`define CR1_IR   4
`define CR1_IF   2
`define CR1_SO   1
`define CR1_OE   0
`define PAIR_TIS 5
`define PAIR_WIDE 4
// ==============================================================
// Mode codes and count clock
`define MODE_ONESHOT 4'h0
`define MODE_CONT    4'h1
`define MODE_FREE    4'h2
`define MODE_FPWM    4'h3
`define MODE_VPWM    4'h4
`define MODE_PWC_H   4'h5
`define MODE_PWC_L   4'h6
`define MODE_PWC_RR  4'h7
`define MODE_PWC_FF  4'h8
`define MODE_PWC_HC  4'h9
`define MODE_CAP_RF  4'hA
`define MODE_CAP_FF  4'hB
`define MODE_CAP_RC  4'hD
`define MODE_CAP_FC  4'hE
`define CLK_SEL_EXT  3'h7
`define COUNT_MAX    8'hFF
`endif

//--- inc/timer_pkg.sv
// Types shared by the composite timer files
package timer_pkg;
    typedef enum logic [2:0] {KIND_INT, KIND_FPWM, KIND_VPWM, KIND_PWC, KIND_CAP} kind_t;
endpackage

//--- verilog/timer_unit.sv
// One 8-bit up counter with clear and carry, chained for 16-bit work
`include "timer_defs.svh"
module timer_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             clr_i,
    input  wire logic             inc_i,
    output logic      [WIDTH-1:0] count_o,
    output logic                  carry_o
);
    // ==============================================================
    // Counter
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_o <= '0;
        end else if (clr_i) begin
            count_o <= '0;
        end else if (inc_i) begin
            count_o <= count_o + 1'b1;
        end
    end

    // Carry feeds the upper counter when chained
    assign carry_o = inc_i && (count_o == {WIDTH{1'b1}});
endmodule // timer_unit

//--- verilog/composite_timer.sv
// One channel of the 8/16-bit composite timer: registers, counters, modes and pins
`include "timer_defs.svh"
// Summary of operation
// - Timer A pin turns output when enabled in interval, PWM or pulse-width mode
// - In 16-bit operation timer A pin carries the combined timer output
// - Timer A pin level is undefined when enabled in capture mode
// - In 8-bit operation timer B pin turns output in interval, fixed PWM, pulse-width
// - Timer B pin undefined in 16-bit with variable PWM or capture
// - Shared event pin feeds both timers' event inputs together, except while timer A takes the serial link
// - Event input clocks counting in interval/PWM, is the measured signal otherwise
// - In 16-bit operation timer B's event input is ignored, except variable PWM
// - Reload/overflow request needs flag, request enable and flag enable all set
// - Mode 0000 one-shot, 0001 continuous, 0010 free-run interval timer
// - Mode 0011 fixed-cycle PWM, 0100 variable-cycle PWM using both counters
// - Modes 0101 to 1001 select the five pulse-width measurements
// - Modes 1010 to 1100 capture free-running, 1101 to 1111 capture with clear
// - Starting in variable PWM loads the other timer's mode with 0100
// - Starting in variable PWM clears the 16-bit mode bit
// - Mode field writes are ignored while the timer runs
// - Data-full and output level bits read back; writes to them do nothing
// - Two counters work as two 8-bit timers or one 16-bit timer
// - Starting counts from zero; stopping halts and zeroes the count
// - With request enable, measure flag or enabled reload flag raises a request
module composite_timer (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [6:0]  prescale_tick_i,
    input  wire logic        shared_event_in_pin_i,
    input  wire logic        internal_serial_link_in_i,
    input  wire logic        port_dir_a_i,
    input  wire logic        port_dir_b_i,
    input  wire logic        port_data_a_i,
    input  wire logic        port_data_b_i,
    output logic             timer_a_out_pin_o,
    output logic             timer_a_out_oe_n_o,
    output logic             timer_b_out_pin_o,
    output logic             timer_b_out_oe_n_o,
    output logic             irq_o
);
    // ==============================================================
    // State
    logic [7:0]           cr0_q  [0:1];
    logic [7:0]           data_q [0:1];
    logic [7:0]           cap_q  [0:1];
    logic [7:0]           cnt    [0:1];
    logic [3:0]           m      [0:1];
    timer_pkg::kind_t     k      [0:1];
    logic [1:0]           run_q, hold_q, ie_q, ir_q, bf_q, if_q, so_q, oe_q;
    logic [1:0]           out_q, meas_q, evp_q;
    logic [1:0]           run_d, hold_d, start, swclr;
    logic [1:0]           ev, rise, fall, tick, en, act, inc, carry, clr, clr_own;
    logic [1:0]           match, hit, ovf, st_e, end_e, cap_e, store, capev;
    logic [1:0]           wr_cr0, wr_cr1, wr_data, rd_data;
    logic [2:0]           sync_q;
    logic                 pin_lvl_q, tis_q, wide_q, couple, vpwm_any, auto_a, auto_b;
    logic [3:0]           filt_q;
    logic [15:0]          cnt16, data16;

    function automatic timer_pkg::kind_t kind_of(input logic [3:0] mode);
        if (mode <= `MODE_FREE) kind_of = timer_pkg::KIND_INT;
        else if (mode == `MODE_FPWM) kind_of = timer_pkg::KIND_FPWM;
        else if (mode == `MODE_VPWM) kind_of = timer_pkg::KIND_VPWM;
        else if (mode < `MODE_CAP_RF) kind_of = timer_pkg::KIND_PWC;
        else kind_of = timer_pkg::KIND_CAP;
    endfunction

    // ==============================================================
    // Bus decode
    assign wr_cr0  = {wr_i && addr_i == `ADDR_CR0_B, wr_i && addr_i == `ADDR_CR0_A};
    assign wr_cr1  = {wr_i && addr_i == `ADDR_CR1_B, wr_i && addr_i == `ADDR_CR1_A};
    assign wr_data = {wr_i && addr_i == `ADDR_DATA_B, wr_i && addr_i == `ADDR_DATA_A};
    assign rd_data = {rd_i && addr_i == `ADDR_DATA_B, rd_i && addr_i == `ADDR_DATA_A};

    // ==============================================================
    // Event pin: three flops, level taken once the last two agree
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_q    <= 3'h0;
            pin_lvl_q <= 1'b0;
            evp_q     <= 2'h0;
        end else begin
            sync_q <= {sync_q[1:0], shared_event_in_pin_i};
            if (sync_q[1] == sync_q[2]) begin
                pin_lvl_q <= sync_q[2];
            end
            evp_q <= ev;
        end
    end

    // Timer A may take the serial link instead; otherwise the pin reaches both timers
    assign ev    = {pin_lvl_q, tis_q ? internal_serial_link_in_i : pin_lvl_q};
    assign rise  = ev & ~evp_q;
    assign fall  = ~ev & evp_q;
    assign cnt16  = {cnt[1], cnt[0]};
    assign data16 = {data_q[1], data_q[0]};

    // ==============================================================
    // Per-timer control decode
    always_comb begin : ctl
        logic [2:0] sel;
        sel = 3'h0;
        for (int i = 0; i < 2; i++) begin
            m[i] = cr0_q[i][3:0];
            k[i] = kind_of(m[i]);
            act[i] = run_q[i] && !hold_q[i] && !(i == 1 && wide_q);
            sel = cr0_q[i][6:4];
            // External ticks only clock the counter in interval and PWM work
            if (sel == `CLK_SEL_EXT) begin
                tick[i] = rise[i] && (k[i] == timer_pkg::KIND_INT ||
                          k[i] == timer_pkg::KIND_FPWM || k[i] == timer_pkg::KIND_VPWM);
            end else begin
                tick[i] = prescale_tick_i[sel];
            end
            en[i] = act[i] && tick[i] && (k[i] != timer_pkg::KIND_PWC || meas_q[i]);
            st_e[i] = (m[i] == `MODE_PWC_H || m[i] == `MODE_PWC_RR || m[i] == `MODE_PWC_HC)
                      ? rise[i] : fall[i];
            end_e[i] = (m[i] == `MODE_PWC_H || m[i] == `MODE_PWC_FF || m[i] == `MODE_PWC_HC)
                       ? fall[i] : rise[i];
            if (m[i] == `MODE_CAP_RF || m[i] == `MODE_CAP_RC) cap_e[i] = rise[i];
            else if (m[i] == `MODE_CAP_FF || m[i] == `MODE_CAP_FC) cap_e[i] = fall[i];
            else cap_e[i] = rise[i] || fall[i];
        end
        // Chained: the upper counter counts on the lower carry only
        inc[0] = en[0];
        inc[1] = wide_q ? (en[0] && carry[0]) : en[1];
        match[0] = wide_q ? (cnt16 == data16) : (cnt[0] == data_q[0]);
        match[1] = cnt[1] == data_q[1];
        ovf[0] = wide_q ? carry[1] : carry[0];
        ovf[1] = carry[1] && !wide_q;
        for (int i = 0; i < 2; i++) begin
            hit[i]   = en[i] && match[i];
            store[i] = act[i] && k[i] == timer_pkg::KIND_PWC && end_e[i] && meas_q[i] && !bf_q[i];
            capev[i] = act[i] && k[i] == timer_pkg::KIND_CAP && cap_e[i];
            clr_own[i] = swclr[i] || (hit[i] && (m[i] == `MODE_CONT || k[i] == timer_pkg::KIND_VPWM))
                       || (act[i] && k[i] == timer_pkg::KIND_PWC && st_e[i])
                       || (capev[i] && m[i] >= `MODE_CAP_RC);
        end
        clr[0] = clr_own[0];
        clr[1] = wide_q ? clr_own[0] : clr_own[1];
    end

    for (genvar g = 0; g < 2; g++) begin : g_cnt
        timer_unit #(.WIDTH(8)) u_cnt (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .clr_i   (clr[g]),
            .inc_i   (inc[g]),
            .count_o (cnt[g]),
            .carry_o (carry[g])
        );
    end

    // ==============================================================
    // Run and suspend, coupled in 16-bit and variable PWM
    always_comb begin : run_next
        run_d    = run_q;
        hold_d   = hold_q;
        vpwm_any = k[0] == timer_pkg::KIND_VPWM || k[1] == timer_pkg::KIND_VPWM;
        couple   = wide_q || vpwm_any;
        for (int i = 0; i < 2; i++) begin
            if (hit[i] && m[i] == `MODE_ONESHOT) begin
                run_d[i] = 1'b0;
                if (wide_q) run_d[1] = 1'b0;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (wr_cr1[i] && !(wide_q && i == 1)) begin
                if (couple) begin
                    run_d  = {2{wdata_i[`CR1_RUN]}};
                    hold_d = {2{wdata_i[`CR1_HOLD]}};
                end else begin
                    run_d[i]  = wdata_i[`CR1_RUN];
                    hold_d[i] = wdata_i[`CR1_HOLD];
                end
            end
        end
        start = run_d & ~run_q;
        swclr = run_d ^ run_q;
    end

    // ==============================================================
    // Configuration registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 2; i++) begin
                cr0_q[i]  <= `RESET_BYTE;
                data_q[i] <= `RESET_BYTE;
            end
            {run_q, hold_q, ie_q, so_q, oe_q} <= 10'h000;
            {tis_q, wide_q, filt_q} <= 6'h00;
        end else begin
            run_q  <= run_d;
            hold_q <= hold_d;
            for (int i = 0; i < 2; i++) begin
                if (wr_cr0[i]) begin
                    cr0_q[i][7:4] <= wdata_i[7:4];
                    if (!run_q[i]) cr0_q[i][3:0] <= wdata_i[3:0];
                end
                if (start[i] && k[i] == timer_pkg::KIND_VPWM) begin
                    cr0_q[1-i][3:0] <= `MODE_VPWM;
                end
                if (wr_cr1[i]) begin
                    ie_q[i] <= wdata_i[`CR1_IE];
                    oe_q[i] <= wdata_i[`CR1_OE];
                    if (!run_q[i] || (wide_q && i == 1)) so_q[i] <= wdata_i[`CR1_SO];
                end
                if (wr_data[i]) data_q[i] <= wdata_i;
            end
            // Output level bits are not stored from the bus
            if (wr_i && addr_i == `ADDR_PAIR_CTL) begin
                tis_q  <= wdata_i[`PAIR_TIS];
                wide_q <= wdata_i[`PAIR_WIDE];
                filt_q <= wdata_i[3:0];
            end else if ((|start) && vpwm_any) begin
                wide_q <= 1'b0;
            end
        end
    end

    // ==============================================================
    // Flags: a hardware set beats a same-cycle software clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            {ir_q, if_q, bf_q} <= 6'h00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((k[i] != timer_pkg::KIND_PWC && k[i] != timer_pkg::KIND_CAP) ||
                    (i == 1 && wide_q)) ir_q[i] <= 1'b0;
                else if (store[i] || capev[i]) ir_q[i] <= 1'b1;
                else if (wr_cr1[i] && !wdata_i[`CR1_IR]) ir_q[i] <= 1'b0;
                if (k[i] == timer_pkg::KIND_VPWM || (i == 1 && wide_q)) if_q[i] <= 1'b0;
                else if ((hit[i] && k[i] == timer_pkg::KIND_INT) || (ovf[i] && act[i] &&
                         (k[i] == timer_pkg::KIND_PWC || k[i] == timer_pkg::KIND_CAP)))
                    if_q[i] <= 1'b1;
                else if (wr_cr1[i] && !wdata_i[`CR1_IF]) if_q[i] <= 1'b0;
            end
            // Data-full moves only by measurement, data reads and, for timer B, 16-bit operation; never by writes
            if (store[0]) bf_q[0] <= 1'b1;
            else if (wide_q ? rd_data[1] : rd_data[0]) bf_q[0] <= 1'b0;
            if (wide_q) bf_q[1] <= 1'b0;
            else if (store[1]) bf_q[1] <= 1'b1;
            else if (rd_data[1]) bf_q[1] <= 1'b0;
        end
    end

    // ==============================================================
    // Measurement, capture and output levels
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cap_q[0] <= `RESET_BYTE;
            cap_q[1] <= `RESET_BYTE;
            meas_q   <= 2'h0;
            out_q    <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (store[i] || capev[i]) begin
                    cap_q[i] <= cnt[i];
                    if (i == 0 && wide_q) cap_q[1] <= cnt[1];
                end
                if (!run_d[i]) meas_q[i] <= 1'b0;
                else if (act[i] && k[i] == timer_pkg::KIND_PWC && st_e[i]) meas_q[i] <= 1'b1;
                else if (act[i] && k[i] == timer_pkg::KIND_PWC && end_e[i]) meas_q[i] <= 1'b0;
                if (start[i]) begin
                    out_q[i] <= so_q[i];
                end else if (act[i]) begin
                    unique case (k[i])
                        timer_pkg::KIND_INT:  if (hit[i]) out_q[i] <= !out_q[i];
                        // 16-bit compare drives timer A for the whole pair
                        timer_pkg::KIND_FPWM: out_q[i] <= (i == 0 && wide_q) ?
                                              (cnt16 < data16) : (cnt[i] < data_q[i]);
                        // Low for timer B's width, high up to timer A's cycle
                        timer_pkg::KIND_VPWM: out_q[i] <= cnt[0] >= data_q[1];
                        // Capture and pulse-width leave the level as it is
                        timer_pkg::KIND_PWC, timer_pkg::KIND_CAP: out_q[i] <= out_q[i];
                    endcase
                end
            end
        end
    end

    // ==============================================================
    // Pins: the timer takes the pin over from the port direction bit
    assign auto_a = oe_q[0] && k[0] != timer_pkg::KIND_CAP;
    assign auto_b = oe_q[1] && !wide_q && (k[1] == timer_pkg::KIND_INT ||
                    k[1] == timer_pkg::KIND_FPWM || k[1] == timer_pkg::KIND_PWC);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_a_out_pin_o  <= 1'b0;
            timer_a_out_oe_n_o <= 1'b1;
            timer_b_out_pin_o  <= 1'b0;
            timer_b_out_oe_n_o <= 1'b1;
        end else begin
            timer_a_out_pin_o  <= auto_a ? out_q[0] : port_data_a_i;
            timer_a_out_oe_n_o <= !(auto_a || port_dir_a_i);
            // In 16-bit operation pin B is left to the port logic
            timer_b_out_pin_o  <= auto_b ? out_q[1] : port_data_b_i;
            timer_b_out_oe_n_o <= !(auto_b || port_dir_b_i);
        end
    end

    // A reload flag only requests when its own enable is set too
    assign irq_o = |(ie_q & (ir_q | (if_q & {cr0_q[1][`CR0_IFE], cr0_q[0][`CR0_IFE]})));

    // ==============================================================
    // Read path: measuring modes read the captured count
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= `RESET_BYTE;
        end else if (!rd_i) begin
            rdata_o <= `RESET_BYTE;
        end else begin
            unique case (addr_i)
                `ADDR_CR0_A:    rdata_o <= cr0_q[0];
                `ADDR_CR0_B:    rdata_o <= cr0_q[1];
                `ADDR_CR1_A:    rdata_o <= {run_q[0], hold_q[0], ie_q[0], ir_q[0],
                                            bf_q[0], if_q[0], so_q[0], oe_q[0]};
                `ADDR_CR1_B:    rdata_o <= {run_q[1], hold_q[1], ie_q[1], ir_q[1],
                                            bf_q[1], if_q[1], so_q[1], oe_q[1]};
                `ADDR_DATA_A:   rdata_o <= (k[0] >= timer_pkg::KIND_PWC) ? cap_q[0] : data_q[0];
                `ADDR_DATA_B:   rdata_o <= (k[wide_q ? 0 : 1] >= timer_pkg::KIND_PWC)
                                           ? cap_q[1] : data_q[1];
                `ADDR_PAIR_CTL: rdata_o <= {out_q[1], out_q[0], tis_q, wide_q, filt_q};
                default:        rdata_o <= `RESET_BYTE;
            endcase
        end
    end

    // ==============================================================
    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    start_zero_a: assert property ($rose(run_q[0]) |-> cnt[0] == 8'h00)
        else $error("count not zero at start");
    stop_zero_a: assert property ($fell(run_q[0]) |-> cnt[0] == 8'h00 ##1 cnt[0] == 8'h00)
        else $error("count not held at zero after stop");
    // A partner start in variable PWM may still load the mode of a running timer
    mode_lock_a: assert property ($past(run_q[0]) && !$past(start[1]) && run_q[0]
                                  |-> $stable(cr0_q[0][3:0]))
        else $error("mode changed while running");
    vpwm_load_a: assert property (start[0] && k[0] == timer_pkg::KIND_VPWM
                                  |=> cr0_q[1][3:0] == `MODE_VPWM)
        else $error("partner mode not loaded");
    wide_clear_a: assert property ((|start) && vpwm_any |=> !wide_q)
        else $error("16-bit bit not cleared");
    pin_a_dir_a: assert property (oe_q[0] && k[0] == timer_pkg::KIND_INT
                                  |=> !timer_a_out_oe_n_o)
        else $error("pin A not driven");
    pin_b_dir_a: assert property (oe_q[1] && !wide_q && k[1] == timer_pkg::KIND_FPWM
                                  |=> !timer_b_out_oe_n_o)
        else $error("pin B not driven");
    irq_gate_a: assert property (!ie_q[1] && ie_q[0] && !ir_q[0] && !cr0_q[0][`CR0_IFE]
                                 |-> !irq_o)
        else $error("request without flag enable");
    shared_in_a: assert property (!tis_q |-> rise[0] == rise[1] && fall[0] == fall[1])
        else $error("event inputs differ");
endmodule // composite_timer

//--- tb/pulse_source.sv
// Model of the external pulse source that stands on the shared event pin
module pulse_source (
    input  wire logic clk_i,
    input  wire logic fire_i,
    output logic      pin_o,
    output logic      port_dir_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // ==========================================
    // Pin behaviour
    // The pin stays an input so the timer sees the source, not the port
    assign port_dir_o = 1'b0;
    // Pulse is six cycles wide so the synchroniser never drops it
    assign pin_o = (cnt > 0);
    always @(posedge clk_i) begin
        if (fire_i) begin
            cnt <= 6;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // pulse_source

//--- tb/tb.sv
// Self-checking testbench of one composite timer channel
`include "timer_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, fire = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [7:0]  wdata_i = 8'h00, rdata_o;
    logic [6:0]  tick = 7'h00;
    logic        ev_pin, dir, a_pin, a_oe_n, b_pin, b_oe_n, irq_o;
    int          miscompares = 0, cmp_count = 0;
    always #5 clk = ~clk;
    always @(posedge clk) tick <= {6'h00, ~tick[0]};
    composite_timer DUT (.clk_i(clk), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .prescale_tick_i(tick), .shared_event_in_pin_i(ev_pin),
        .internal_serial_link_in_i(1'b0), .port_dir_a_i(dir), .port_dir_b_i(dir),
        .port_data_a_i(1'b0), .port_data_b_i(1'b0), .timer_a_out_pin_o(a_pin),
        .timer_a_out_oe_n_o(a_oe_n), .timer_b_out_pin_o(b_pin),
        .timer_b_out_oe_n_o(b_oe_n), .irq_o(irq_o));
    pulse_source SRC (.clk_i(clk), .fire_i(fire), .pin_o(ev_pin), .port_dir_o(dir));
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk);
        wr_i <= 1'b0;
    endtask
    // Read data is only valid in the cycle after the strobe, so sample it there
    task automatic rd(input logic [11:0] a, input logic [7:0] m, output logic [7:0] v);
        @(posedge clk);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk);
        rd_i <= 1'b0;
        #1 v = rdata_o & m;
    endtask
    task automatic wait_irq();
        // Look just after the edge so the flags launched there have settled
        for (int i = 0; i < 60 && irq_o !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic reset_values();
        logic [11:0] map [8] = '{`ADDR_CR1_B, `ADDR_CR1_A, `ADDR_CR0_B, `ADDR_CR0_A,
                                 `ADDR_DATA_B, `ADDR_DATA_A, `ADDR_PAIR_CTL, 12'h100};
        logic [7:0] v;
        foreach (map[i]) begin
            rd(map[i], 8'hFF, v);
            chk(v, `RESET_BYTE);
        end
        wr(`ADDR_PAIR_CTL, 8'hFF);
        rd(`ADDR_PAIR_CTL, 8'hFF, v);
        chk(v, 8'h3F);
        wr(`ADDR_PAIR_CTL, 8'h00);
    endtask
    task automatic interval_irq();
        logic [7:0] v;
        wr(`ADDR_DATA_A, 8'h03);
        wr(`ADDR_CR0_A, 8'h81);
        wr(`ADDR_CR1_A, 8'hA1);
        wait_irq();
        chk({7'h00, irq_o}, 8'h01);
        chk({7'h00, a_oe_n}, 8'h00);
        @(posedge clk);
        #1;
        chk({7'h00, a_pin}, 8'h01);
        rd(`ADDR_CR1_A, 8'hF5, v);
        chk(v, 8'hA5);
        wr(`ADDR_CR0_A, 8'h05);
        rd(`ADDR_CR0_A, 8'hFF, v);
        chk(v, 8'h01);
        @(posedge clk);
        chk({7'h00, irq_o}, 8'h00);
        wr(`ADDR_CR1_A, 8'h00);
    endtask
    task automatic vpwm_start();
        logic [7:0] v;
        wr(`ADDR_PAIR_CTL, 8'h10);
        wr(`ADDR_CR0_A, 8'h04);
        wr(`ADDR_CR1_A, 8'h80);
        rd(`ADDR_CR0_B, 8'h0F, v);
        chk(v, `MODE_VPWM);
        rd(`ADDR_PAIR_CTL, 8'h30, v);
        chk(v, 8'h00);
        wr(`ADDR_CR1_A, 8'h00);
    endtask
    task automatic capture_b();
        logic [7:0] v;
        wr(`ADDR_CR0_B, {4'h0, `MODE_CAP_RF});
        // Timer A must leave variable PWM, or starting B pulls B back into it
        wr(`ADDR_CR0_A, {4'h0, `MODE_ONESHOT});
        wr(`ADDR_CR1_A, 8'h80);
        repeat (20) @(posedge clk);
        rd(`ADDR_CR1_A, 8'h84, v);
        chk(v, 8'h04);
        wr(`ADDR_CR1_B, 8'hA1);
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        wait_irq();
        chk({7'h00, irq_o}, 8'h01);
        rd(`ADDR_CR1_B, 8'hF0, v);
        chk(v, 8'hB0);
        chk({6'h00, b_oe_n, b_pin}, 8'h02);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_i <= 1'b0;
        reset_values();
        interval_irq();
        vpwm_start();
        capture_b();
        end_of_test();
    end
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end
endmodule // tb
